// ==== verilog/stc_device.sv ====
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ns
// Overview of operation
// RULE1: all logic runs on the reference clock
// RULE2: input sync rising edge captures timer
// RULE3: output sync pin toggles at programmed interval
// RULE4: link selectable as transmitter or receiver
// RULE5: receiver mode: far end drives all wires
// RULE6: frame: start, lock, epoch, seconds, zeros, ns, accuracy, crc
// RULE7: crc covers lock through accuracy bits
// RULE8: code gives time of previous heartbeat edge
// RULE9: received bits kept in three words
// RULE10: receiver checks crc, flags mismatch
// RULE11: heartbeat edge captures free-running count
// RULE12: time and free count offered as pair
// RULE13: drift value adjusts timer step
// RULE14: heartbeat rate set by software, starts frame
// RULE15: heartbeat starts shifting out transmit memory
// RULE16: crc follows accuracy with no gap
// RULE17: bit clock from own clock or pll tick
// RULE18: msb first, change on fall, sample on rise
module stc_device (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt
  output logic irq,
  // external sync pins
  input wire logic [1:0] sync_in,
  output logic [1:0] sync_out,
  output logic [1:0] sync_oe_n,
  // low-jitter half-bit tick, same clock
  input wire logic pll_tick,
  // serial time link
  stc_if.dev lnk
);
  import stc_pkg::*;
  logic [5:0] cfg_reg;
  logic [15:0] hb_rate_reg, div_reg, dv_reg, hbc_reg;
  logic [31:0] drift_reg, tx0_reg, tx1_reg, tx2_reg, rx0_reg, rx1_reg, rx2_reg;
  logic [31:0] pair_reg, hbf_reg, txcap_reg, free_reg, rd_val;
  logic [31:0] scap_reg [2];
  logic [31:0] si_reg [2];
  logic [63:0] timer_reg;
  logic [4:0] s1, s2, s3, stb, rise, ist_reg, imsk_reg, ev;
  logic [1:0] sev, sdir;
  logic lock_reg, crcerr_reg, rd_ok, en, txm, tx_act, rx_act, tick, fall;
  logic bclk_reg, hb_reg, dat_reg, oe_n_reg, tx_on, txd_p, rxd_p, rxe_p;
  logic [6:0] txc_reg, rxc_reg;
  logic [88:0] tsh_reg;
  logic [7:0] tcrc_reg, rcrc_reg;
  logic [95:0] rsh_reg;
  logic [96:0] full;
  stc_rx_state_t rxs_reg;
  wire acc_go = psel & penable & ~pready;
  wire wr_go = psel & penable & pready & pwrite;

  function automatic logic wr_at(input logic [7:0] a);
    return wr_go && (paddr[31:8] == 24'h00_0000) && (paddr[7:0] == a);
  endfunction : wr_at

  assign en = cfg_reg[`STC_CFG_EN];
  assign txm = cfg_reg[`STC_CFG_TX];
  assign sdir = cfg_reg[`STC_CFG_SDIR +: 2];
  assign tx_act = en & txm;
  assign rx_act = en & ~txm;

  // ==========================================
  // register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= `STC_CFG_RST;
      hb_rate_reg <= `STC_HB_RST;
      div_reg <= `STC_DIV_RST;
      drift_reg <= '0;
      tx0_reg <= '0;
      tx1_reg <= '0;
      tx2_reg <= '0;
      imsk_reg <= '0;
      si_reg[0] <= `STC_SI_RST;
      si_reg[1] <= `STC_SI_RST;
    end else begin
      if (wr_at(`STC_A_CFG)) cfg_reg <= pwdata[5:0]; // RULE4
      if (wr_at(`STC_A_HB)) hb_rate_reg <= pwdata[15:0];
      if (wr_at(`STC_A_DIV)) div_reg <= pwdata[15:0];
      if (wr_at(`STC_A_DRIFT)) drift_reg <= pwdata;
      if (wr_at(`STC_A_TX0)) tx0_reg <= pwdata;
      if (wr_at(`STC_A_TX1)) tx1_reg <= pwdata;
      if (wr_at(`STC_A_TX2)) tx2_reg <= pwdata;
      if (wr_at(`STC_A_IMSK)) imsk_reg <= pwdata[4:0];
      if (wr_at(`STC_A_SI0)) si_reg[0] <= pwdata;
      if (wr_at(`STC_A_SI1)) si_reg[1] <= pwdata;
    end
  end

  // ==========================================
  // read decode and apb answer
  always_comb begin
    rd_ok = paddr[31:8] == 24'h00_0000;
    case (paddr[7:0])
      `STC_A_CFG: rd_val = {26'h000_0000, cfg_reg};
      `STC_A_HB: rd_val = {16'h0000, hb_rate_reg};
      `STC_A_DIV: rd_val = {16'h0000, div_reg};
      `STC_A_DRIFT: rd_val = drift_reg;
      `STC_A_TX0: rd_val = tx0_reg;
      `STC_A_TX1: rd_val = tx1_reg;
      `STC_A_TX2: rd_val = tx2_reg;
      `STC_A_RX0: rd_val = rx0_reg; // RULE9
      `STC_A_RX1: rd_val = rx1_reg;
      `STC_A_RX2: rd_val = rx2_reg;
      `STC_A_RXST: rd_val = {30'h0000_0000, crcerr_reg, lock_reg}; // RULE10
      `STC_A_PAIR: rd_val = pair_reg; // RULE12
      `STC_A_TLO: rd_val = timer_reg[47:16];
      `STC_A_THI: rd_val = {16'h0000, timer_reg[63:48]};
      `STC_A_SC0: rd_val = scap_reg[0];
      `STC_A_SC1: rd_val = scap_reg[1];
      `STC_A_SI0: rd_val = si_reg[0];
      `STC_A_SI1: rd_val = si_reg[1];
      `STC_A_IST: rd_val = {27'h000_0000, ist_reg};
      `STC_A_IMSK: rd_val = {27'h000_0000, imsk_reg};
      `STC_A_TXCAP: rd_val = txcap_reg;
      default: begin
        rd_val = '0;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= acc_go;
      if (acc_go) begin
        prdata <= pwrite ? 32'h0000_0000 : (rd_ok ? rd_val : 32'h0000_0000);
        pslverr <= ~rd_ok;
      end
    end
  end

  // ==========================================
  // timer and free-running count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_reg <= '0;
      free_reg <= '0;
    end else begin
      timer_reg <= timer_reg + `STC_NS_STEP + {{32{drift_reg[31]}}, drift_reg}; // RULE1 RULE13
      free_reg <= free_reg + 32'h0000_0001;
    end
  end

  // ==========================================
  // pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      stb <= '0;
    end else begin
      s1 <= {sync_in, lnk.dat, lnk.hb, lnk.bclk};
      s2 <= s1;
      s3 <= s2;
      stb <= (s2 & ~(s2 ^ s3)) | (stb & (s2 ^ s3));
    end
  end
  assign rise = ~(s2 ^ s3) & s3 & ~stb;
  assign full = {rsh_reg, stb[2]};

  // ==========================================
  // external sync pins
  genvar gi;
  for (gi = 0; gi < 2; gi++) begin : g_ext
    logic [31:0] cnt_reg;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        scap_reg[gi] <= '0;
        cnt_reg <= '0;
        sync_out[gi] <= 1'b0;
        sync_oe_n[gi] <= 1'b1;
      end else begin
        sync_oe_n[gi] <= ~sdir[gi];
        if (!sdir[gi] && rise[3+gi]) scap_reg[gi] <= timer_reg[47:16]; // RULE2
        if (!sdir[gi]) begin
          cnt_reg <= '0;
        end else if (cnt_reg >= si_reg[gi] - 32'h0000_0001) begin
          cnt_reg <= '0;
          sync_out[gi] <= ~sync_out[gi]; // RULE3
        end else begin
          cnt_reg <= cnt_reg + 32'h0000_0001;
        end
      end
    end
    assign sev[gi] = ~sdir[gi] & rise[3+gi];
  end

  // ==========================================
  // transmitter
  assign tick = cfg_reg[`STC_CFG_PLL] ? pll_tick : (dv_reg >= div_reg - 16'h0001); // RULE17
  assign fall = tx_act & tick & bclk_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dv_reg <= '0;
      bclk_reg <= 1'b0;
    end else begin
      dv_reg <= (!tx_act || tick) ? 16'h0000 : dv_reg + 16'h0001;
      bclk_reg <= tx_act & (tick ? ~bclk_reg : bclk_reg);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hb_reg <= 1'b0;
      dat_reg <= 1'b0;
      oe_n_reg <= 1'b1;
      tx_on <= 1'b0;
      txd_p <= 1'b0;
      hbc_reg <= '0;
      txc_reg <= '0;
      tsh_reg <= '0;
      tcrc_reg <= `STC_CRC_INIT;
      txcap_reg <= '0;
    end else begin
      oe_n_reg <= ~tx_act; // RULE4
      txd_p <= 1'b0;
      if (!tx_act) begin
        hb_reg <= 1'b0;
        dat_reg <= 1'b0;
        tx_on <= 1'b0;
        hbc_reg <= '0;
      end else if (fall) begin
        if (hbc_reg >= hb_rate_reg - 16'h0001) begin
          hbc_reg <= '0;
          hb_reg <= 1'b1; // RULE14
          dat_reg <= 1'b1;
          tsh_reg <= {tx2_reg[0], tx2_reg[31:16], tx0_reg, 2'b00, tx1_reg[29:0],
                      tx2_reg[15:8]}; // RULE6 RULE15
          txc_reg <= 7'h01;
          tcrc_reg <= `STC_CRC_INIT;
          tx_on <= 1'b1;
          txcap_reg <= timer_reg[47:16]; // RULE8
        end else begin
          hbc_reg <= hbc_reg + 16'h0001;
          hb_reg <= 1'b0;
          if (!tx_on) begin
            dat_reg <= 1'b0;
          end else if (txc_reg <= `STC_PAY_LAST) begin
            dat_reg <= tsh_reg[88]; // RULE18
            tsh_reg <= {tsh_reg[87:0], 1'b0};
            tcrc_reg <= stc_crc_step(tcrc_reg, tsh_reg[88]); // RULE7
            txc_reg <= txc_reg + 7'h01;
          end else begin
            dat_reg <= tcrc_reg[7]; // RULE16
            tcrc_reg <= {tcrc_reg[6:0], 1'b0};
            txc_reg <= txc_reg + 7'h01;
            if (txc_reg == `STC_TX_LAST) begin
              tx_on <= 1'b0;
              txd_p <= 1'b1;
            end
          end
        end
      end
    end
  end
  assign lnk.d_bclk = bclk_reg;
  assign lnk.d_hb = hb_reg;
  assign lnk.d_dat = dat_reg;
  assign lnk.d_oe_n = oe_n_reg;

  // ==========================================
  // receiver
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxs_reg <= RX_IDLE;
      rsh_reg <= '0;
      rxc_reg <= '0;
      rcrc_reg <= `STC_CRC_INIT;
      hbf_reg <= '0;
      pair_reg <= '0;
      rx0_reg <= '0;
      rx1_reg <= '0;
      rx2_reg <= '0;
      lock_reg <= 1'b0;
      crcerr_reg <= 1'b0;
      rxd_p <= 1'b0;
      rxe_p <= 1'b0;
    end else begin
      rxd_p <= 1'b0;
      rxe_p <= 1'b0;
      if (!rx_act) begin
        rxs_reg <= RX_IDLE;
      end else if (rise[1]) begin
        hbf_reg <= free_reg; // RULE11
        rxs_reg <= RX_HUNT;
      end else if (rise[0]) begin
        case (rxs_reg)
          RX_HUNT: begin
            if (stb[2]) begin
              rxs_reg <= RX_SHIFT;
              rxc_reg <= '0;
              rcrc_reg <= `STC_CRC_INIT;
            end
          end
          RX_SHIFT: begin
            rsh_reg <= full[95:0]; // RULE18
            rxc_reg <= rxc_reg + 7'h01;
            if (rxc_reg < `STC_PAY_LAST) rcrc_reg <= stc_crc_step(rcrc_reg, stb[2]); // RULE7
            if (rxc_reg == `STC_RX_LAST) begin
              rxs_reg <= RX_IDLE;
              rx0_reg <= full[79:48]; // RULE6 RULE9
              rx1_reg <= full[47:16];
              rx2_reg <= {full[95:80], full[15:0]};
              lock_reg <= full[96];
              crcerr_reg <= full[7:0] != rcrc_reg; // RULE10
              rxe_p <= full[7:0] != rcrc_reg;
              pair_reg <= hbf_reg; // RULE8 RULE12
              rxd_p <= 1'b1;
            end
          end
          default: rxs_reg <= RX_IDLE;
        endcase
      end
    end
  end

  // ==========================================
  // interrupts
  assign ev = {txd_p, sev, rxe_p, rxd_p};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_reg <= '0;
      irq <= 1'b0;
    end else begin
      ist_reg <= (ist_reg & ~(wr_at(`STC_A_IST) ? pwdata[4:0] : 5'h00)) | ev;
      irq <= |(ist_reg & imsk_reg);
    end
  end
endmodule : stc_device

// ==== shared/stc_map.svh ====
`ifndef STC_MAP_SVH
`define STC_MAP_SVH
// ==========================================
// register offsets
`define STC_A_CFG 8'h00
`define STC_A_HB 8'h04
`define STC_A_DIV 8'h08
`define STC_A_DRIFT 8'h0C
`define STC_A_TX0 8'h10
`define STC_A_TX1 8'h14
`define STC_A_TX2 8'h18
`define STC_A_RX0 8'h1C
`define STC_A_RX1 8'h20
`define STC_A_RX2 8'h24
`define STC_A_RXST 8'h28
`define STC_A_PAIR 8'h2C
`define STC_A_TLO 8'h30
`define STC_A_THI 8'h34
`define STC_A_SC0 8'h38
`define STC_A_SC1 8'h3C
`define STC_A_SI0 8'h40
`define STC_A_SI1 8'h44
`define STC_A_IST 8'h48
`define STC_A_IMSK 8'h4C
`define STC_A_TXCAP 8'h50
// ==========================================
// field positions
`define STC_CFG_EN 0
`define STC_CFG_TX 1
`define STC_CFG_PLL 2
`define STC_CFG_SDIR 4
// ==========================================
// reset values and checksum polynomial
`define STC_CFG_RST 6'h00
`define STC_HB_RST 16'h0080
`define STC_DIV_RST 16'h0004
`define STC_SI_RST 32'h0000_0400
`define STC_CRC_POLY 8'h07
`define STC_CRC_INIT 8'h00
// ==========================================
// frame layout and timing
`define STC_PAY_LAST 7'h59
`define STC_TX_LAST 7'h61
`define STC_RX_LAST 7'h60
`define STC_PCLK_PERIOD_NS 8
`define STC_NS_STEP (64'(`STC_PCLK_PERIOD_NS) << 16)
`endif

// ==== shared/stc_pkg.sv ====
`include "stc_map.svh"
package stc_pkg;
  typedef enum logic [1:0] {RX_IDLE, RX_HUNT, RX_SHIFT} stc_rx_state_t;

  // one serial step of the frame checksum, msb first
  function automatic logic [7:0] stc_crc_step(input logic [7:0] c, input logic b);
    logic fb;
    fb = c[7] ^ b;
    return {c[6:0], 1'b0} ^ (fb ? `STC_CRC_POLY : 8'h00);
  endfunction : stc_crc_step
endpackage : stc_pkg

// ==== shared/stc_if.sv ====
`timescale 1ns/1ns
interface stc_if;
  logic d_bclk;
  logic d_hb;
  logic d_dat;
  logic d_oe_n;
  logic f_bclk;
  logic f_hb;
  logic f_dat;
  logic f_oe_n;
  logic bclk;
  logic hb;
  logic dat;
  // wire level from the enables; undriven reads low
  assign bclk = !d_oe_n ? d_bclk : (!f_oe_n ? f_bclk : 1'b0);
  assign hb = !d_oe_n ? d_hb : (!f_oe_n ? f_hb : 1'b0);
  assign dat = !d_oe_n ? d_dat : (!f_oe_n ? f_dat : 1'b0);
  modport dev (output d_bclk, output d_hb, output d_dat, output d_oe_n,
               input bclk, input hb, input dat);
  modport far (output f_bclk, output f_hb, output f_dat, output f_oe_n,
               input bclk, input hb, input dat);
endinterface : stc_if

// ==== verilog/stc_far.sv ====
`timescale 1ns/1ns
module stc_far (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // role and bit timing
  input wire logic tx_en,
  input wire logic [15:0] half_div,
  // frame to send
  input wire logic send,
  input wire logic tx_lock,
  input wire logic [15:0] tx_epoch,
  input wire logic [31:0] tx_sec,
  input wire logic [29:0] tx_ns,
  input wire logic [7:0] tx_acc,
  output logic busy,
  // received frame
  output logic rx_valid,
  output logic rx_lock,
  output logic [15:0] rx_epoch,
  output logic [31:0] rx_sec,
  output logic [29:0] rx_ns,
  output logic [7:0] rx_acc,
  output logic rx_crc_err,
  // serial time link
  stc_if.far lnk
);
  import stc_pkg::*;
  logic [2:0] s1, s2, s3, stb, rise;
  logic [15:0] dv_reg;
  logic bclk_reg, hb_reg, dat_reg, oe_n_reg, pend, tx_on;
  logic [6:0] txc_reg, rxc_reg;
  logic [88:0] tsh_reg;
  logic [7:0] tcrc_reg, rcrc_reg;
  logic [95:0] rsh_reg;
  logic [96:0] full;
  stc_rx_state_t rxs_reg;
  logic tick, fall;

  // ==========================================
  // pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      stb <= '0;
    end else begin
      s1 <= {lnk.dat, lnk.hb, lnk.bclk};
      s2 <= s1;
      s3 <= s2;
      stb <= (s2 & ~(s2 ^ s3)) | (stb & (s2 ^ s3));
    end
  end
  assign rise = ~(s2 ^ s3) & s3 & ~stb;
  assign full = {rsh_reg, stb[2]};

  // ==========================================
  // transmitter
  assign tick = dv_reg >= half_div - 16'h0001;
  assign fall = tx_en & tick & bclk_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dv_reg <= '0;
      bclk_reg <= 1'b0;
    end else begin
      dv_reg <= (!tx_en || tick) ? 16'h0000 : dv_reg + 16'h0001;
      bclk_reg <= tx_en & (tick ? ~bclk_reg : bclk_reg);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hb_reg <= 1'b0;
      dat_reg <= 1'b0;
      oe_n_reg <= 1'b1;
      pend <= 1'b0;
      tx_on <= 1'b0;
      busy <= 1'b0;
      txc_reg <= '0;
      tsh_reg <= '0;
      tcrc_reg <= `STC_CRC_INIT;
    end else begin
      oe_n_reg <= ~tx_en; // RULE5
      if (!tx_en) begin
        hb_reg <= 1'b0;
        dat_reg <= 1'b0;
        pend <= 1'b0;
        tx_on <= 1'b0;
        busy <= 1'b0;
      end else begin
        if (send && !busy) begin
          pend <= 1'b1;
          busy <= 1'b1;
        end
        if (fall) begin
          if (pend) begin
            pend <= 1'b0;
            hb_reg <= 1'b1;
            dat_reg <= 1'b1;
            tsh_reg <= {tx_lock, tx_epoch, tx_sec, 2'b00, tx_ns, tx_acc}; // RULE6
            txc_reg <= 7'h01;
            tcrc_reg <= `STC_CRC_INIT;
            tx_on <= 1'b1;
          end else begin
            hb_reg <= 1'b0;
            if (!tx_on) begin
              dat_reg <= 1'b0;
            end else if (txc_reg <= `STC_PAY_LAST) begin
              dat_reg <= tsh_reg[88]; // RULE18
              tsh_reg <= {tsh_reg[87:0], 1'b0};
              tcrc_reg <= stc_crc_step(tcrc_reg, tsh_reg[88]); // RULE7
              txc_reg <= txc_reg + 7'h01;
            end else begin
              dat_reg <= tcrc_reg[7];
              tcrc_reg <= {tcrc_reg[6:0], 1'b0};
              txc_reg <= txc_reg + 7'h01;
              if (txc_reg == `STC_TX_LAST) begin
                tx_on <= 1'b0;
                busy <= 1'b0;
              end
            end
          end
        end
      end
    end
  end
  assign lnk.f_bclk = bclk_reg;
  assign lnk.f_hb = hb_reg;
  assign lnk.f_dat = dat_reg;
  assign lnk.f_oe_n = oe_n_reg;

  // ==========================================
  // receiver
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxs_reg <= RX_IDLE;
      rsh_reg <= '0;
      rxc_reg <= '0;
      rcrc_reg <= `STC_CRC_INIT;
      rx_valid <= 1'b0;
      rx_lock <= 1'b0;
      rx_epoch <= '0;
      rx_sec <= '0;
      rx_ns <= '0;
      rx_acc <= '0;
      rx_crc_err <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (tx_en) begin
        rxs_reg <= RX_IDLE;
      end else if (rise[1]) begin
        rxs_reg <= RX_HUNT; // RULE8
      end else if (rise[0]) begin
        case (rxs_reg)
          RX_HUNT: begin
            if (stb[2]) begin
              rxs_reg <= RX_SHIFT;
              rxc_reg <= '0;
              rcrc_reg <= `STC_CRC_INIT;
            end
          end
          RX_SHIFT: begin
            rsh_reg <= full[95:0]; // RULE18
            rxc_reg <= rxc_reg + 7'h01;
            if (rxc_reg < `STC_PAY_LAST) begin
              rcrc_reg <= stc_crc_step(rcrc_reg, stb[2]); // RULE7
            end
            if (rxc_reg == `STC_RX_LAST) begin
              rxs_reg <= RX_IDLE;
              rx_valid <= 1'b1;
              rx_lock <= full[96]; // RULE6
              rx_epoch <= full[95:80];
              rx_sec <= full[79:48];
              rx_ns <= full[45:16];
              rx_acc <= full[15:8];
              rx_crc_err <= full[7:0] != rcrc_reg;
            end
          end
          default: rxs_reg <= RX_IDLE;
        endcase
      end
    end
  end
endmodule : stc_far

// ==== verification/stc_asserts.sv ====
`timescale 1ns/1ns
module stc_asserts (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // device drives
  input wire logic d_bclk,
  input wire logic d_hb,
  input wire logic d_dat,
  input wire logic d_oe_n,
  // far end drives
  input wire logic f_bclk,
  input wire logic f_hb,
  input wire logic f_dat,
  input wire logic f_oe_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================
  // device frame tracker
  logic pb;
  logic ph;
  logic pf;
  logic [6:0] cnt;
  logic [7:0] crc;
  wire fall = pb & ~d_bclk;
  wire start = fall & d_hb & ~ph;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pb <= 1'b0;
      ph <= 1'b0;
      pf <= 1'b0;
    end else begin
      pb <= d_bclk;
      ph <= d_hb;
      pf <= f_bclk;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 7'h7F;
      crc <= 8'h00;
    end else if (start) begin
      cnt <= 7'h00;
      crc <= 8'h00;
    end else if (fall && cnt != 7'h7F) begin
      cnt <= cnt + 7'h01;
      if (cnt < 7'h59) begin
        crc <= {crc[6:0], 1'b0} ^ ((crc[7] ^ d_dat) ? 8'h07 : 8'h00);
      end
    end
  end
  sequence d_start_s;
    start;
  endsequence
  sequence crc_bit_s;
    fall && !start && cnt >= 7'h59 && cnt <= 7'h60;
  endsequence
  // ==========================================
  // wire rules
  start_bit_a: assert property (d_start_s |-> d_dat)
    else $error("frame start bit not one");
  hb_width_a: assert property (fall && ph |-> !d_hb)
    else $error("heartbeat longer than one bit");
  dat_edge_a: assert property (
    !d_oe_n && !$past(d_oe_n) && $changed(d_dat) |-> fall)
    else $error("device data moved off a clock fall");
  crc_tail_a: assert property (crc_bit_s |-> d_dat == crc[3'(7'h60 - cnt)])
    else $error("sent checksum bit wrong");
  frame_len_a: assert property (fall && cnt == 7'h61 |-> !d_dat || start)
    else $error("data not idle after frame");
  far_start_a: assert property ($rose(f_hb) |-> f_dat)
    else $error("far start bit not one");
  far_edge_a: assert property (
    !f_oe_n && !$past(f_oe_n) && $changed(f_dat) |-> pf && !f_bclk)
    else $error("far data moved off a clock fall");
  one_driver_a: assert property (!d_oe_n |-> f_oe_n)
    else $error("both ends drive the link");
endmodule : stc_asserts

// ==== verification/tb_serial_time_code_sync.sv ====
`timescale 1ns/1ns
`include "stc_map.svh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin error_cnt++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_serial_time_code_sync;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0000_0000, pwdata = 32'h0000_0000, prdata;
  logic pready, pslverr, irq, pll_tick = 1'b0, tx_en = 1'b0, send = 1'b0;
  logic [1:0] sync_in = 2'b00, sync_out, sync_oe_n;
  logic [15:0] half_div = 16'h0008, r_ep;
  logic [88:0] fv = '0;
  logic rx_valid, r_lock, r_err;
  logic [31:0] r_sec;
  logic [29:0] r_ns;
  logic [7:0] r_acc;
  int error_cnt = 0, tests_run = 0;
  int cyc = 0, pc = 0;
  int hb_t[$];
  logic hb_d = 1'b0;
  logic [88:0] exp_q[$];
  always #4 pclk = ~pclk;
  stc_if lnk();
  stc_device i_stc_device (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .sync_in(sync_in), .sync_out(sync_out),
    .sync_oe_n(sync_oe_n), .pll_tick(pll_tick), .lnk(lnk.dev));
  stc_far i_stc_far (.pclk(pclk), .presetn(presetn), .tx_en(tx_en), .half_div(half_div),
    .send(send), .tx_lock(fv[88]), .tx_epoch(fv[87:72]), .tx_sec(fv[71:40]),
    .tx_ns(fv[37:8]), .tx_acc(fv[7:0]), .busy(), .rx_valid(rx_valid), .rx_lock(r_lock),
    .rx_epoch(r_ep), .rx_sec(r_sec), .rx_ns(r_ns), .rx_acc(r_acc), .rx_crc_err(r_err),
    .lnk(lnk.far));
  stc_asserts i_stc_asserts (.pclk(pclk), .presetn(presetn), .d_bclk(lnk.d_bclk),
    .d_hb(lnk.d_hb), .d_dat(lnk.d_dat), .d_oe_n(lnk.d_oe_n), .f_bclk(lnk.f_bclk),
    .f_hb(lnk.f_hb), .f_dat(lnk.f_dat), .f_oe_n(lnk.f_oe_n));
  // ==========================================
  // pll half-bit tick, far heartbeat cycle log
  always @(posedge pclk) begin
    pc <= pc + 1;
    pll_tick <= (pc % 8) == 7;
    cyc <= cyc + 1;
    hb_d <= lnk.f_hb;
    if (lnk.f_hb && !hb_d) hb_t.push_back(cyc);
  end
  // ==========================================
  // model and bus tasks
  function automatic logic [7:0] crc89(input logic [88:0] v);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 88; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? `STC_CRC_POLY : 8'h00);
    return c;
  endfunction : crc89
  function automatic logic [88:0] rnd_frame();
    logic [95:0] r;
    r = {$urandom(), $urandom(), $urandom()};
    r[39:38] = 2'b00;
    return r[88:0];
  endfunction : rnd_frame
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h00_0000, a};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) error_cnt++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic e;
    apb(1'b1, a, d, x, e);
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [31:0] ex);
    logic [31:0] x;
    logic e;
    apb(1'b0, a, 32'h0000_0000, x, e);
    `CHK(x, ex)
  endtask : rchk
  task automatic wait_hi(input logic use_irq);
    int n;
    for (n = 0; n < 6000 && (use_irq ? irq : rx_valid) !== 1'b1; n++) @(posedge pclk);
    if (n == 6000) error_cnt++;
  endtask : wait_hi
  // ==========================================
  // watchdog, over four times the expected run
  initial begin
    #400000;
    error_cnt++;
    give_verdict();
  end
  // ==========================================
  // main sequence
  initial begin : main
    logic [31:0] v;
    logic [31:0] w;
    logic e;
    logic b;
    int n;
    logic [88:0] f;
    void'($urandom(39395));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk(`STC_A_CFG, 32'(`STC_CFG_RST));
    rchk(`STC_A_HB, 32'(`STC_HB_RST));
    rchk(`STC_A_SI1, `STC_SI_RST);
    apb(1'b0, 8'h54, 32'h0000_0000, v, e);
    `CHK({v, e}, 33'h0_0000_0001)
    wr(`STC_A_DIV, 32'h0000_0008);
    for (int i = 0; i < 2; i++) begin
      f = rnd_frame();
      wr(`STC_A_IMSK, (i == 0) ? 32'h0000_0010 : 32'h0000_0000);
      wr(`STC_A_TX0, f[71:40]);
      wr(`STC_A_TX1, {2'b00, f[37:8]});
      wr(`STC_A_TX2, {f[87:72], f[7:0], 7'h00, f[88]});
      exp_q.push_back(f);
      wr(`STC_A_CFG, (i == 0) ? 32'h0000_0003 : 32'h0000_0007);
      wait_hi(1'b0);
      f = exp_q.pop_front();
      `CHK({r_lock, r_ep, r_sec, 2'b00, r_ns, r_acc, r_err}, {f, 1'b0})
      `CHK(irq, (i == 0))
      repeat (32) @(posedge pclk);
      wr(`STC_A_CFG, 32'h0000_0000);
      rchk(`STC_A_IST, 32'h0000_0010);
      wr(`STC_A_IST, 32'h0000_001F);
      rchk(`STC_A_IST, 32'h0000_0000);
    end
    wr(`STC_A_CFG, 32'h0000_0001);
    wr(`STC_A_IMSK, 32'h0000_0001);
    tx_en <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      fv <= rnd_frame();
      send <= 1'b1;
      @(posedge pclk);
      send <= 1'b0;
      exp_q.push_back(fv);
      wait_hi(1'b1);
      f = exp_q.pop_front();
      rchk(`STC_A_RX0, f[71:40]);
      rchk(`STC_A_RX1, {2'b00, f[37:8]});
      rchk(`STC_A_RX2, {f[87:72], f[7:0], crc89(f)});
      rchk(`STC_A_RXST, {31'h0000_0000, f[88]});
      apb(1'b0, `STC_A_PAIR, 32'h0000_0000, v, e);
      if (i == 1) `CHK(v - w, 32'(hb_t[1] - hb_t[0]))
      w = v;
      wr(`STC_A_IST, 32'h0000_0001);
      @(posedge pclk);
      `CHK(irq, 1'b0)
    end
    for (int i = 0; i < 2; i++) begin
      wr(`STC_A_DRIFT, (i == 1) ? 32'h0002_0000 : 32'h0000_0000);
      apb(1'b0, `STC_A_TLO, 32'h0000_0000, v, e);
      apb(1'b0, `STC_A_TLO, 32'h0000_0000, w, e);
      `CHK(w - v, 32'h0000_0020 + 32'(i * 8))
    end
    apb(1'b0, `STC_A_TLO, 32'h0000_0000, v, e);
    sync_in <= 2'b11;
    repeat (8) @(posedge pclk);
    apb(1'b0, `STC_A_SC1, 32'h0000_0000, w, e);
    `CHK(w > v && w - v < 32'h0000_0100, 1'b1)
    rchk(`STC_A_IST, 32'h0000_000C);
    wr(`STC_A_SI0, 32'h0000_0010);
    wr(`STC_A_CFG, 32'h0000_0031);
    @(posedge pclk);
    `CHK(sync_oe_n, 2'b00)
    b = sync_out[0];
    for (n = 0; n < 100 && sync_out[0] === b; n++) @(posedge pclk);
    b = sync_out[0];
    for (n = 0; n < 100 && sync_out[0] === b; n++) @(posedge pclk);
    `CHK(n, 16)
    give_verdict();
  end
endmodule : tb_serial_time_code_sync
